// file: hw/bad_defines.svh
// Register offsets, field positions, reset values and cycle costs of the byte add datapath
`ifndef BAD_DEFINES_SVH
`define BAD_DEFINES_SVH

`define BAD_OFF_CTRL 8'h00
`define BAD_OFF_OPERAND 8'h04
`define BAD_OFF_ACC_EXT 8'h08
`define BAD_OFF_ACC_MID 8'h0c
`define BAD_OFF_ACC_LOW 8'h10
`define BAD_OFF_SR 8'h14
`define BAD_OFF_OMR 8'h18
`define BAD_OFF_DREG 8'h1c
`define BAD_OFF_X0 8'h20
`define BAD_OFF_Y0 8'h24
`define BAD_OFF_PTR1 8'h28
`define BAD_OFF_PTR2 8'h2c
`define BAD_OFF_STATUS 8'h30

`define BAD_CTRL_DEST16 2
`define BAD_CTRL_SRCY 3
`define BAD_OMR_CLIP 0
`define BAD_OMR_RAMCODE 1
`define BAD_ST_BUSY 0
`define BAD_ST_REJECT 1
`define BAD_ST_CYC_LSB 2

`define BAD_SR_C 0
`define BAD_SR_V 1
`define BAD_SR_Z 2
`define BAD_SR_N 3
`define BAD_SR_U 4
`define BAD_SR_E 5
`define BAD_SR_L 6

`define BAD_SR_RST 16'h0000
`define BAD_OMR_RST 2'h0
`define BAD_WORD_RST 16'h0000
`define BAD_EXT_RST 4'h0

`define BAD_DUAL_CYCLES 2'h1
`define BAD_BYTE_CYCLES 2'h2
`define BAD_BYTE_WORDS 2'h2

`endif

// file: hw/bad_pkg.sv
// Types and sign extension helpers of the byte add datapath
`default_nettype none
package bad_pkg;
   typedef enum logic [1:0] {
      BAD_OP_NONE = 2'h0,
      BAD_OP_DUAL = 2'h1,
      BAD_OP_IMM = 2'h2,
      BAD_OP_MEM = 2'h3
   } bad_op_t;

   typedef enum logic [1:0] {
      BAD_S_IDLE = 2'h0,
      BAD_S_FETCH = 2'h1,
      BAD_S_EXEC = 2'h3
   } bad_state_t;

   function automatic logic [19:0] bad_sext16(input logic [15:0] v);
      bad_sext16 = {{4{v[15]}}, v};
   endfunction : bad_sext16

   function automatic logic [19:0] bad_sext9(input logic [8:0] v);
      bad_sext9 = {{11{v[8]}}, v};
   endfunction : bad_sext9

   function automatic logic [19:0] bad_sext8(input logic [7:0] v);
      bad_sext8 = {{12{v[7]}}, v};
   endfunction : bad_sext8
endpackage : bad_pkg
`default_nettype wire

// file: hw/bad_byte_alu.sv
// 20-bit adder with byte condition flags
`timescale 1ns/1ps
`default_nettype none
`include "bad_defines.svh"
module bad_byte_alu (
   input wire logic [19:0] dest_val,
   input wire logic [19:0] opnd_val,
   output logic [19:0] sum,
   output logic [5:0] flags
);
   import bad_pkg::*;
   logic [8:0] low_sum;
   logic ext_used;

   always_comb begin
      sum = dest_val + opnd_val;
      low_sum = {1'b0, dest_val[7:0]} + {1'b0, opnd_val[7:0]};
      // Extension in use when bits 19..15 are not all copies of the sign
      ext_used = !((&sum[19:15]) || (~|sum[19:15]));
      flags = 6'h00;
      flags[`BAD_SR_C] = low_sum[8];
      flags[`BAD_SR_V] = (dest_val[7] == opnd_val[7]) && (sum[7] != dest_val[7]);
      flags[`BAD_SR_Z] = (sum[7:0] == 8'h00);
      flags[`BAD_SR_N] = sum[7];
      flags[`BAD_SR_U] = ~(sum[15] ^ sum[14]);
      flags[`BAD_SR_E] = ext_used;
   end
endmodule : bad_byte_alu
`default_nettype wire

// file: hw/bad_word_alu.sv
// 36-bit register add with optional limiting and full flags
`timescale 1ns/1ps
`default_nettype none
`include "bad_defines.svh"
module bad_word_alu (
   input wire logic [35:0] acc_val,
   input wire logic [15:0] src_val,
   input wire logic clip,
   output logic [35:0] result,
   output logic [6:0] flags
);
   import bad_pkg::*;
   logic [35:0] opnd;
   logic [36:0] wide;
   logic [35:0] raw;
   logic ext_used;

   always_comb begin
      opnd = {bad_sext16(src_val), 16'h0000};
      wide = {1'b0, acc_val} + {1'b0, opnd};
      raw = wide[35:0];
      ext_used = !((&raw[35:31]) || (~|raw[35:31]));
      result = raw;
      if (clip && ext_used) begin
         result = raw[35] ? 36'hf_8000_0000 : 36'h0_7fff_ffff;
      end
      flags = 7'h00;
      flags[`BAD_SR_C] = wide[36];
      flags[`BAD_SR_V] = (acc_val[35] == opnd[35]) && (raw[35] != acc_val[35]);
      flags[`BAD_SR_Z] = (result == 36'h0_0000_0000);
      flags[`BAD_SR_N] = result[35];
      flags[`BAD_SR_U] = ~(result[31] ^ result[30]);
      flags[`BAD_SR_E] = !((&result[35:31]) || (~|result[35:31]));
      flags[`BAD_SR_L] = clip && ext_used;
   end
endmodule : bad_word_alu
`default_nettype wire

// file: hw/bad_datapath.sv
// Byte add datapath top: register file, sequencer and memory read ports
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bad_defines.svh"
module bad_datapath (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [15:0] dmem_a_addr,
   output logic dmem_a_rd,
   input wire logic [15:0] dmem_a_rdata,
   output logic [15:0] dmem_b_addr,
   output logic dmem_b_rd,
   input wire logic [15:0] dmem_b_rdata
);
   import bad_pkg::*;

   // Bus slave state
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_en;
   logic busy;

   // Datapath state
   bad_state_t state_q, state_d;
   bad_op_t op_q, op_d;
   logic [3:0] ctrl_q, ctrl_d;
   logic [15:0] operand_q, operand_d;
   logic [3:0] ext_q, ext_d;
   logic [15:0] mid_q, mid_d;
   logic [15:0] low_q, low_d;
   logic [15:0] sr_q, sr_d;
   logic [1:0] omr_q, omr_d;
   logic [15:0] dreg_q, dreg_d;
   logic [15:0] x0_q, x0_d;
   logic [15:0] y0_q, y0_d;
   logic [15:0] ptr1_q, ptr1_d;
   logic [15:0] ptr2_q, ptr2_d;
   logic reject_q, reject_d;
   logic [1:0] cyc_q, cyc_d;
   logic [1:0] last_cyc_q, last_cyc_d;
   logic load_pend_q, load_pend_d;
   logic [15:0] a_addr_q, a_addr_d;
   logic [15:0] b_addr_q, b_addr_d;
   logic a_rd_q, a_rd_d;
   logic b_rd_q, b_rd_d;

   // Operand selection and ALU wires
   logic [7:0] mem_byte;
   logic [19:0] byte_dest;
   logic [19:0] byte_opnd;
   logic [19:0] byte_sum;
   logic [5:0] byte_flags;
   logic [35:0] word_res;
   logic [6:0] word_flags;
   logic [15:0] word_src;
   bad_op_t new_op;

   function automatic logic [31:0] read_mux(input logic [7:0] addr);
      case (addr)
         `BAD_OFF_CTRL: read_mux = {28'h0, ctrl_q};
         `BAD_OFF_OPERAND: read_mux = {16'h0, operand_q};
         `BAD_OFF_ACC_EXT: read_mux = {28'h0, ext_q};
         `BAD_OFF_ACC_MID: read_mux = {16'h0, mid_q};
         `BAD_OFF_ACC_LOW: read_mux = {16'h0, low_q};
         `BAD_OFF_SR: read_mux = {16'h0, sr_q};
         `BAD_OFF_OMR: read_mux = {30'h0, omr_q};
         `BAD_OFF_DREG: read_mux = {16'h0, dreg_q};
         `BAD_OFF_X0: read_mux = {16'h0, x0_q};
         `BAD_OFF_Y0: read_mux = {16'h0, y0_q};
         `BAD_OFF_PTR1: read_mux = {16'h0, ptr1_q};
         `BAD_OFF_PTR2: read_mux = {16'h0, ptr2_q};
         `BAD_OFF_STATUS: read_mux = {28'h0, last_cyc_q, reject_q, busy};
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   // Bus slave: one wait cycle, held off while an operation runs
   always_comb begin
      busy = (state_q != BAD_S_IDLE) || load_pend_q;
      ack_d = (avs_read || avs_write) && !ack_q && !busy;
      rdata_d = ack_d ? read_mux(avs_address) : rdata_q;
      wr_en = avs_write && ack_q;
      avs_waitrequest = !ack_q;
      avs_readdata = rdata_q;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   bad_byte_alu u_byte_alu (
      .dest_val(byte_dest),
      .opnd_val(byte_opnd),
      .sum(byte_sum),
      .flags(byte_flags)
   );

   bad_word_alu u_word_alu (
      .acc_val({ext_q, mid_q, low_q}),
      .src_val(word_src),
      .clip(omr_q[`BAD_OMR_CLIP]),
      .result(word_res),
      .flags(word_flags)
   );

   always_comb begin
      mem_byte = operand_q[0] ? dmem_a_rdata[15:8] : dmem_a_rdata[7:0];
      byte_opnd = (op_q == BAD_OP_MEM) ? bad_sext8(mem_byte) : bad_sext9(operand_q[8:0]);
      byte_dest = ctrl_q[`BAD_CTRL_DEST16] ? bad_sext16(dreg_q) : {ext_q, mid_q};
      word_src = ctrl_q[`BAD_CTRL_SRCY] ? y0_q : x0_q;
      new_op = bad_op_t'(avs_writedata[1:0]);
   end

   // Sequencer and register file
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      ctrl_d = ctrl_q;
      operand_d = operand_q;
      ext_d = ext_q;
      mid_d = mid_q;
      low_d = low_q;
      sr_d = sr_q;
      omr_d = omr_q;
      dreg_d = dreg_q;
      x0_d = x0_q;
      y0_d = y0_q;
      ptr1_d = ptr1_q;
      ptr2_d = ptr2_q;
      reject_d = reject_q;
      cyc_d = cyc_q;
      last_cyc_d = last_cyc_q;
      load_pend_d = 1'b0;
      a_addr_d = a_addr_q;
      b_addr_d = b_addr_q;
      a_rd_d = 1'b0;
      b_rd_d = 1'b0;

      // Parallel reads land one cycle after the add
      if (load_pend_q) begin
         y0_d = dmem_a_rdata;
         x0_d = dmem_b_rdata;
      end

      if (wr_en) begin
         case (avs_address)
            `BAD_OFF_OPERAND: operand_d = avs_writedata[15:0];
            `BAD_OFF_ACC_EXT: ext_d = avs_writedata[3:0];
            `BAD_OFF_ACC_MID: mid_d = avs_writedata[15:0];
            `BAD_OFF_ACC_LOW: low_d = avs_writedata[15:0];
            `BAD_OFF_SR: sr_d = avs_writedata[15:0];
            `BAD_OFF_OMR: omr_d = avs_writedata[1:0];
            `BAD_OFF_DREG: dreg_d = avs_writedata[15:0];
            `BAD_OFF_X0: x0_d = avs_writedata[15:0];
            `BAD_OFF_Y0: y0_d = avs_writedata[15:0];
            `BAD_OFF_PTR1: ptr1_d = avs_writedata[15:0];
            `BAD_OFF_PTR2: ptr2_d = avs_writedata[15:0];
            `BAD_OFF_STATUS: begin
               if (avs_writedata[`BAD_ST_REJECT]) begin
                  reject_d = 1'b0;
               end
            end
            default: ;
         endcase
      end

      case (state_q)
         BAD_S_IDLE: begin
            if (wr_en && (avs_address == `BAD_OFF_CTRL) && (new_op != BAD_OP_NONE)) begin
               ctrl_d = avs_writedata[3:0];
               op_d = new_op;
               cyc_d = 2'h1;
               if (new_op == BAD_OP_DUAL) begin
                  if (omr_q[`BAD_OMR_RAMCODE]) begin
                     reject_d = 1'b1;
                  end else begin
                     a_addr_d = ptr1_q;
                     b_addr_d = ptr2_q;
                     a_rd_d = 1'b1;
                     b_rd_d = 1'b1;
                     ptr1_d = ptr1_q + 16'h0001;
                     ptr2_d = ptr2_q + 16'h0001;
                     state_d = BAD_S_EXEC;
                  end
               end else begin
                  if (new_op == BAD_OP_MEM) begin
                     a_addr_d = {1'b0, operand_q[15:1]};
                     a_rd_d = 1'b1;
                  end
                  state_d = BAD_S_FETCH;
               end
            end
         end
         BAD_S_FETCH: begin
            cyc_d = cyc_q + 2'h1;
            state_d = BAD_S_EXEC;
         end
         BAD_S_EXEC: begin
            state_d = BAD_S_IDLE;
            last_cyc_d = cyc_q;
            if (op_q == BAD_OP_DUAL) begin
               ext_d = word_res[35:32];
               mid_d = word_res[31:16];
               low_d = word_res[15:0];
               sr_d[5:0] = word_flags[5:0];
               sr_d[`BAD_SR_L] = sr_q[`BAD_SR_L] || word_flags[`BAD_SR_L]
                  || word_flags[`BAD_SR_V];
               load_pend_d = 1'b1;
            end else begin
               // No limiting path on byte adds
               if (ctrl_q[`BAD_CTRL_DEST16]) begin
                  dreg_d = byte_sum[15:0];
               end else begin
                  ext_d = byte_sum[19:16];
                  mid_d = byte_sum[15:0];
               end
               sr_d = {sr_q[15:6], byte_flags};
            end
         end
         default: state_d = BAD_S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= BAD_S_IDLE;
         op_q <= BAD_OP_NONE;
         ctrl_q <= 4'h0;
         operand_q <= `BAD_WORD_RST;
         ext_q <= `BAD_EXT_RST;
         mid_q <= `BAD_WORD_RST;
         low_q <= `BAD_WORD_RST;
         sr_q <= `BAD_SR_RST;
         omr_q <= `BAD_OMR_RST;
         dreg_q <= `BAD_WORD_RST;
         x0_q <= `BAD_WORD_RST;
         y0_q <= `BAD_WORD_RST;
         ptr1_q <= `BAD_WORD_RST;
         ptr2_q <= `BAD_WORD_RST;
         reject_q <= 1'b0;
         cyc_q <= 2'h0;
         last_cyc_q <= 2'h0;
         load_pend_q <= 1'b0;
         a_addr_q <= `BAD_WORD_RST;
         b_addr_q <= `BAD_WORD_RST;
         a_rd_q <= 1'b0;
         b_rd_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         ctrl_q <= ctrl_d;
         operand_q <= operand_d;
         ext_q <= ext_d;
         mid_q <= mid_d;
         low_q <= low_d;
         sr_q <= sr_d;
         omr_q <= omr_d;
         dreg_q <= dreg_d;
         x0_q <= x0_d;
         y0_q <= y0_d;
         ptr1_q <= ptr1_d;
         ptr2_q <= ptr2_d;
         reject_q <= reject_d;
         cyc_q <= cyc_d;
         last_cyc_q <= last_cyc_d;
         load_pend_q <= load_pend_d;
         a_addr_q <= a_addr_d;
         b_addr_q <= b_addr_d;
         a_rd_q <= a_rd_d;
         b_rd_q <= b_rd_d;
      end
   end

   always_comb begin
      dmem_a_addr = a_addr_q;
      dmem_a_rd = a_rd_q;
      dmem_b_addr = b_addr_q;
      dmem_b_rd = b_rd_q;
   end
endmodule : bad_datapath
`default_nettype wire

// file: verif/bad_dmem_model.sv
// Two-port synchronous data memory model for the byte add datapath
`timescale 1ns/1ps
`default_nettype none
module bad_dmem_model (
   input wire logic core_clk,
   input wire logic [15:0] a_addr,
   input wire logic a_rd,
   output logic [15:0] a_rdata,
   input wire logic [15:0] b_addr,
   input wire logic b_rd,
   output logic [15:0] b_rdata
);
   function automatic logic [15:0] mword(input logic [15:0] a);
      return {a[7:0] ^ 8'h3c, a[7:0]};
   endfunction : mword
   initial begin
      a_rdata = 16'h0000;
      b_rdata = 16'h0000;
   end
   // Data stands one cycle after the strobe, then scrambles
   always @(posedge core_clk) begin
      a_rdata <= a_rd ? mword(a_addr) : ~a_rdata;
      b_rdata <= b_rd ? mword(b_addr) : ~b_rdata;
   end
endmodule : bad_dmem_model
`default_nettype wire

// file: verif/bad_datapath_assertions.sv
// Port checker of the byte add datapath
`timescale 1ns/1ps
`default_nettype none
module bad_datapath_assertions (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [15:0] dmem_a_addr,
   input wire logic dmem_a_rd,
   input wire logic [15:0] dmem_a_rdata,
   input wire logic [15:0] dmem_b_addr,
   input wire logic dmem_b_rd,
   input wire logic [15:0] dmem_b_rdata
);
   logic [1:0] omr_q, omr_d;
   logic [15:0] opr_q, opr_d;
   wire logic wr_ok = avs_write && !avs_waitrequest;
   wire logic go = wr_ok && avs_address == 8'h00;
   always_comb begin
      omr_d = omr_q;
      opr_d = opr_q;
      if (wr_ok && avs_address == 8'h18) omr_d = avs_writedata[1:0];
      if (wr_ok && avs_address == 8'h04) opr_d = avs_writedata[15:0];
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         omr_q <= 2'h0;
         opr_q <= 16'h0000;
      end else begin
         omr_q <= omr_d;
         opr_q <= opr_d;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_wait_idle: assert property (!avs_read && !avs_write |-> avs_waitrequest)
      else $error("waitrequest low without request");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("ack without a presented request");
   a_rd_pulse: assert property (dmem_a_rd |=> !dmem_a_rd)
      else $error("port A strobe longer than one cycle");
   a_pair_rd: assert property (dmem_b_rd |-> dmem_a_rd)
      else $error("second read without first read");
   a_dual_reads: assert property (go && avs_writedata[1:0] == 2'h1 && !omr_q[1]
      |=> dmem_a_rd && dmem_b_rd ##1 !dmem_b_rd)
      else $error("dual reads not in the single execute cycle");
   a_dual_refuse: assert property (go && avs_writedata[1:0] == 2'h1 && omr_q[1]
      |=> (!dmem_a_rd && !dmem_b_rd) [*3])
      else $error("refused dual add still read memory");
   a_imm_noread: assert property (go && avs_writedata[1:0] == 2'h2
      |=> (!dmem_a_rd && !dmem_b_rd) [*2])
      else $error("immediate add touched memory");
   a_mem_fetch: assert property (go && avs_writedata[1:0] == 2'h3
      |=> dmem_a_rd && dmem_a_addr == {1'b0, opr_q[15:1]} && !dmem_b_rd)
      else $error("memory byte fetch wrong");
endmodule : bad_datapath_assertions
bind bad_datapath bad_datapath_assertions u_bad_datapath_assertions (
   .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .dmem_a_addr(dmem_a_addr), .dmem_a_rd(dmem_a_rd),
   .dmem_a_rdata(dmem_a_rdata), .dmem_b_addr(dmem_b_addr), .dmem_b_rd(dmem_b_rd),
   .dmem_b_rdata(dmem_b_rdata));
`default_nettype wire

// file: verif/bad_datapath_test.sv
// Self-checking bench of the byte add datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module bad_datapath_test;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] a_addr, a_rdata, b_addr, b_rdata;
   logic a_rd, b_rd;
   logic [31:0] q;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   bad_datapath u_bad_datapath (.core_clk(core_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .dmem_a_addr(a_addr), .dmem_a_rd(a_rd),
      .dmem_a_rdata(a_rdata), .dmem_b_addr(b_addr), .dmem_b_rd(b_rd),
      .dmem_b_rdata(b_rdata));
   bad_dmem_model u_bad_dmem_model (.core_clk(core_clk), .a_addr(a_addr), .a_rd(a_rd),
      .a_rdata(a_rdata), .b_addr(b_addr), .b_rd(b_rd), .b_rdata(b_rdata));
   initial forever #2.5 core_clk = ~core_clk;
   task automatic give_verdict();
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rd_chk
   // Sum and flags {E,U,N,Z,V,C} of a byte add
   function automatic logic [25:0] exp_add(input logic [19:0] d, input logic [19:0] o);
      logic [19:0] s;
      logic [8:0] lo;
      s = d + o;
      lo = {1'b0, d[7:0]} + {1'b0, o[7:0]};
      return {s, |s[19:15] & ~&s[19:15], s[15] == s[14], s[7], s[7:0] == 8'h00,
         d[7] == o[7] && s[7] != d[7], lo[8]};
   endfunction : exp_add
   task automatic byte_op(input logic [2:0] ctl, input logic [15:0] opr,
         input logic [19:0] d, input logic [19:0] o);
      logic [25:0] x;
      x = exp_add(d, o);
      wr(8'h08, {28'h0, d[19:16]});
      wr(8'h0c, {16'h0, d[15:0]});
      wr(8'h1c, {16'h0, d[15:0]});
      wr(8'h14, 32'h0000ffff);
      wr(8'h04, {16'h0, opr});
      wr(8'h00, {29'h0, ctl});
      rd_chk(8'h14, {16'h0, 10'h3ff, x[5:0]});
      rd_chk(8'h30, 32'h8);
      if (ctl[2]) rd_chk(8'h1c, {16'h0, x[21:6]});
      else rd_chk(8'h0c, {16'h0, x[21:6]});
      if (!ctl[2]) rd_chk(8'h08, {28'h0, x[25:22]});
   endtask : byte_op
   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 13; i++) rd_chk(8'(i * 4), 32'h0);
      wr(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0);
      wr(8'h10, 32'h1234);
      byte_op(3'h2, 16'h0055, 20'h03122, 20'h00055);
      byte_op(3'h2, 16'h0001, 20'h000ff, 20'h00001);
      byte_op(3'h2, 16'h0001, 20'h0007f, 20'h00001);
      byte_op(3'h2, 16'h01ff, 20'h00000, 20'hfffff);
      wr(8'h18, 32'h1);
      byte_op(3'h2, 16'h00ff, 20'h07fff, 20'h000ff);
      wr(8'h18, 32'h0);
      byte_op(3'h6, 16'h0001, 20'hf8000, 20'h00001);
      byte_op(3'h3, 16'h0161, 20'h03122, 20'hfff8c);
      byte_op(3'h3, 16'h0160, 20'h00010, 20'hfffb0);
      rd_chk(8'h10, 32'h1234);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h0);
      wr(8'h20, 32'h3);
      wr(8'h28, 32'h10);
      wr(8'h2c, 32'h20);
      wr(8'h00, 32'h1);
      rd_chk(8'h0c, 32'h3);
      rd_chk(8'h10, 32'h1234);
      rd_chk(8'h24, {16'h0, u_bad_dmem_model.mword(16'h0010)});
      rd_chk(8'h20, {16'h0, u_bad_dmem_model.mword(16'h0020)});
      rd_chk(8'h28, 32'h11);
      rd_chk(8'h30, 32'h4);
      wr(8'h18, 32'h2);
      wr(8'h00, 32'h1);
      bus(1'b0, 8'h30, 32'h0);
      `CHK(q[1:0], 2'b10)
      rd_chk(8'h0c, 32'h3);
      rd_chk(8'h28, 32'h11);
      wr(8'h30, 32'h2);
      bus(1'b0, 8'h30, 32'h0);
      `CHK(q[1:0], 2'b00)
      // Dual add from Y0 with clip on: sum enters the extension, so it saturates
      wr(8'h18, 32'h1);
      wr(8'h0c, 32'h7fff);
      wr(8'h00, 32'h9);
      rd_chk(8'h0c, 32'h7fff);
      rd_chk(8'h10, 32'hffff);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h30, 32'h4);
      give_verdict();
   end
endmodule : bad_datapath_test
`default_nettype wire
